// ===== core/frs_map.svh
/*
  Register indices, field values, reset values and the analogue threshold of the fan run
  source select block.
  Assumes a register port addressed by Modbus register index.
*/
`ifndef FRS_MAP_SVH
`define FRS_MAP_SVH

// =====================================================================
// Register indices
`define FRS_IDX_SP_SRC      8'h27
`define FRS_IDX_RUN_SRC     8'h28
`define FRS_IDX_ONOFF       8'h29
`define FRS_IDX_SETPOINT    8'h26

// =====================================================================
// Field values
`define FRS_RUN_BUS         16'h0000
`define FRS_RUN_ALWAYS      16'h0001
`define FRS_RUN_DIN         16'h0002
`define FRS_SP_BUS          16'h0000
`define FRS_SP_ANALOG       16'h0001
`define FRS_ONOFF_START     16'h000F
`define FRS_ONOFF_STOP      16'h0000

// =====================================================================
// Reset values
`define FRS_RST_RUN_SRC     16'h0000
`define FRS_RST_SP_SRC      16'h0000
`define FRS_RST_ONOFF       16'h0000
`define FRS_RST_SETPOINT    16'h0000

// Analogue setpoint threshold above which a setpoint counts as given.
`define FRS_ANA_MIN         16'h0000

`endif

// ===== core/frs_pkg.sv
/*
  Types of the fan run source select block.
  Assumes nothing of its surroundings.
*/
package frs_pkg;

  // ===================================================================
  // Run source decoded from the run source register.
  typedef enum logic [1:0] {
    FRS_SRC_BUS,
    FRS_SRC_ALWAYS,
    FRS_SRC_DIN,
    FRS_SRC_BAD
  } frs_run_src_t;

endpackage

// ===== core/frs_sync.sv
/*
  Two flip-flop synchroniser for a bus of pin levels.
  Assumes the inputs are asynchronous to core_clk_i.
*/
`timescale 1ns/1ps

module frs_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // =====================================================================
  // Synchroniser stages; the first stage feeds only the second.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule // frs_sync

// ===== core/frs_top.sv
/*
  Run permission and setpoint source selection of a fan drive, with its
  configuration, on/off and setpoint registers. The run source register
  picks whether running is commanded over the bus, taken from the digital
  terminal or always permitted; the setpoint source register picks the
  bus setpoint register or the analogue terminal word.
  Assumes a register port driven by a Modbus engine on core_clk_i, a
  digital terminal level and an analogue setpoint word from an ADC, both
  asynchronous to core_clk_i.
*/
`timescale 1ns/1ps
`include "frs_map.svh"

module frs_top #(
  parameter int SP_W = 16
) (
  input  wire logic            core_clk_i,
  input  wire logic            rst_i,
  input  wire logic            reg_wr_i,
  input  wire logic            reg_rd_i,
  input  wire logic [7:0]      reg_idx_i,
  input  wire logic [15:0]     reg_wdata_i,
  output logic      [15:0]     reg_rdata_o,
  output logic                 reg_err_o,
  input  wire logic            din_i,
  input  wire logic [SP_W-1:0] analog_sp_i,
  output logic                 run_o,
  output logic      [SP_W-1:0] setpoint_o
);

  // =====================================================================
  // Elaboration check: the setpoint path is at most one register wide.
  if (SP_W < 1 || SP_W > 16) begin : g_chk
    $error("SP_W must be 1 to 16");
  end

  // =====================================================================
  // Register state; each _d is the next value of its _q.
  logic [15:0]           run_src_q;
  logic [15:0]           run_src_d;
  logic [15:0]           sp_src_q;
  logic [15:0]           sp_src_d;
  logic [15:0]           onoff_q;
  logic [15:0]           onoff_d;
  logic [15:0]           bus_sp_q;
  logic [15:0]           bus_sp_d;
  logic [15:0]           rdata_q;
  logic [15:0]           rdata_d;
  logic                  err_q;
  logic                  err_d;

  // Output state and the analogue word filter.
  logic                  run_q;
  logic                  run_d;
  logic [SP_W-1:0]       sp_q;
  logic [SP_W-1:0]       sp_d;
  logic [SP_W-1:0]       ana_prev_q;
  logic [SP_W-1:0]       ana_prev_d;
  logic [SP_W-1:0]       ana_hold_q;
  logic [SP_W-1:0]       ana_hold_d;

  // Synchronised pins and the decoded run source.
  logic [SP_W:0]         pins_s;
  logic [SP_W-1:0]       ana_s;
  logic                  din_s;
  frs_pkg::frs_run_src_t src;

  // =====================================================================
  // Pin synchronisers for the terminal input and the analogue word; no
  // logic reads a pin before it has passed both flip-flops.
  frs_sync #(
    .WIDTH (SP_W + 1)
  ) frs_sync_inst (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .async_i    ({din_i, analog_sp_i}),
    .sync_o     (pins_s)
  );

  // Split the synchronised bus into the terminal level and the word.
  assign din_s = pins_s[SP_W];
  assign ana_s = pins_s[SP_W-1:0];

  // =====================================================================
  // Analogue word filter. The bits of a changing word may be caught in
  // different cycles, so a new word is taken only once two successive
  // synchronised samples agree; until then the last agreed word stands.
  always_comb begin
    ana_prev_d = ana_s;
    ana_hold_d = ana_hold_q;
    if (ana_s == ana_prev_q) begin
      ana_hold_d = ana_s;
    end
  end

  // Registers of the analogue word filter.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ana_prev_q <= '0;
      ana_hold_q <= '0;
    end else begin
      ana_prev_q <= ana_prev_d;
      ana_hold_q <= ana_hold_d;
    end
  end

  // =====================================================================
  // Register writes and reads.
  always_comb begin
    run_src_d = run_src_q;
    sp_src_d  = sp_src_q;
    onoff_d   = onoff_q;
    bus_sp_d  = bus_sp_q;
    rdata_d   = rdata_q;
    err_d     = 1'b0;
    // A write wins over a read in the same cycle; an unmapped index
    // stores nothing and raises the error pulse.
    if (reg_wr_i) begin
      unique case (reg_idx_i)
        `FRS_IDX_RUN_SRC:  run_src_d = reg_wdata_i;
        `FRS_IDX_SP_SRC:   sp_src_d  = reg_wdata_i;
        `FRS_IDX_ONOFF:    onoff_d   = reg_wdata_i;
        `FRS_IDX_SETPOINT: bus_sp_d  = reg_wdata_i;
        default:           err_d     = 1'b1;
      endcase
    end else if (reg_rd_i) begin
      unique case (reg_idx_i)
        `FRS_IDX_RUN_SRC:  rdata_d = run_src_q;
        `FRS_IDX_SP_SRC:   rdata_d = sp_src_q;
        `FRS_IDX_ONOFF:    rdata_d = onoff_q;
        `FRS_IDX_SETPOINT: rdata_d = bus_sp_q;
        default: begin
          rdata_d = 16'h0000;
          err_d   = 1'b1;
        end
      endcase
    end
  end

  // Register bank; reset leaves bus run, bus setpoint and stop.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      run_src_q <= `FRS_RST_RUN_SRC;
      sp_src_q  <= `FRS_RST_SP_SRC;
      onoff_q   <= `FRS_RST_ONOFF;
      bus_sp_q  <= `FRS_RST_SETPOINT;
      rdata_q   <= 16'h0000;
      err_q     <= 1'b0;
    end else begin
      run_src_q <= run_src_d;
      sp_src_q  <= sp_src_d;
      onoff_q   <= onoff_d;
      bus_sp_q  <= bus_sp_d;
      rdata_q   <= rdata_d;
      err_q     <= err_d;
    end
  end

  // Read data and error come straight from their registers.
  assign reg_rdata_o = rdata_q;
  assign reg_err_o   = err_q;

  // =====================================================================
  // Decode of the run source; unknown codes never permit running.
  // The whole word is compared, so a code with high bits set is unknown.
  always_comb begin
    unique case (run_src_q)
      `FRS_RUN_BUS:    src = frs_pkg::FRS_SRC_BUS;
      `FRS_RUN_ALWAYS: src = frs_pkg::FRS_SRC_ALWAYS;
      `FRS_RUN_DIN:    src = frs_pkg::FRS_SRC_DIN;
      default:         src = frs_pkg::FRS_SRC_BAD;
    endcase
  end

  // =====================================================================
  // Setpoint selection. A source code other than bus or analogue gives a
  // zero setpoint rather than a stale one.
  always_comb begin
    if (sp_src_q == `FRS_SP_ANALOG) begin
      sp_d = ana_hold_q;
    end else if (sp_src_q == `FRS_SP_BUS) begin
      sp_d = bus_sp_q[SP_W-1:0];
    end else begin
      sp_d = '0;
    end
  end

  // Setpoint output register.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sp_q <= '0;
    end else begin
      sp_q <= sp_d;
    end
  end

  // =====================================================================
  // Run permission. In terminal mode a running fan also needs a nonzero
  // setpoint from the selected source; in bus mode only the exact start
  // code runs, so a stray write stops the fan rather than starting it.
  always_comb begin
    unique case (src)
      frs_pkg::FRS_SRC_BUS:
        run_d = (onoff_q == `FRS_ONOFF_START);
      frs_pkg::FRS_SRC_ALWAYS:
        run_d = 1'b1;
      frs_pkg::FRS_SRC_DIN:
        run_d = din_s && (sp_d != '0);
      frs_pkg::FRS_SRC_BAD:
        run_d = 1'b0;
    endcase
  end

  // Run permission output register.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      run_q <= 1'b0;
    end else begin
      run_q <= run_d;
    end
  end

  // Outputs come straight from their registers.
  assign run_o      = run_q;
  assign setpoint_o = sp_q;

endmodule // frs_top

// ===== verification/frs_props.sv
/* Assertions on the frs_top ports.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
// ==============================
// Port checker
module frs_props #(
  parameter int SP_W = 16
) (
  input  wire logic            core_clk_i,
  input  wire logic            rst_i,
  input  wire logic            reg_wr_i,
  input  wire logic            reg_rd_i,
  input  wire logic [7:0]      reg_idx_i,
  input  wire logic [15:0]     reg_wdata_i,
  input  wire logic [15:0]     reg_rdata_o,
  input  wire logic            reg_err_o,
  input  wire logic            din_i,
  input  wire logic [SP_W-1:0] analog_sp_i,
  input  wire logic            run_o,
  input  wire logic [SP_W-1:0] setpoint_o
);
  logic [15:0] rs_q;
  logic [15:0] on_q;
  logic [15:0] ss_q;
  logic [15:0] sp_q;
  wire         ok = reg_idx_i inside {[8'h26:8'h29]};
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // Shadow copies of the writable registers.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      {rs_q, on_q, ss_q, sp_q} <= '0;
    end else if (reg_wr_i) begin
      case (reg_idx_i)
        8'h26: sp_q <= reg_wdata_i;
        8'h27: ss_q <= reg_wdata_i;
        8'h28: rs_q <= reg_wdata_i;
        8'h29: on_q <= reg_wdata_i;
        default: ;
      endcase
    end
  end
  a_err_pulse: assert property (
    ##1 reg_err_o == $past((reg_wr_i || reg_rd_i) && !ok)) else $error("err");
  a_src_readback: assert property (
    reg_rd_i && !reg_wr_i && reg_idx_i == 8'h27 |=>
    reg_rdata_o == $past(ss_q)) else $error("readback");
  a_bus_run: assert property (
    rs_q == 16'h0000 |=> run_o == ($past(on_q) == 16'h000F)) else $error("bus");
  a_always_run: assert property (
    rs_q == 16'h0001 |=> run_o) else $error("always");
  a_bad_src: assert property (
    rs_q > 16'h0002 |=> !run_o) else $error("bad src");
  a_din_off: assert property (
    rs_q == 16'h0002 && !$past(din_i, 2) |=> !run_o) else $error("din off");
  a_din_on: assert property (
    rs_q == 16'h0002 && $past(din_i, 2) && ss_q == 16'h0000 &&
    sp_q != 16'h0000 |=> run_o) else $error("din on");
  // Two synchroniser stages, one agreement stage, one output register.
  a_sp_analog: assert property (
    ss_q == 16'h0001 &&
    $past(analog_sp_i, 3) == $past(analog_sp_i, 4) |=>
    setpoint_o == $past(analog_sp_i, 4)) else $error("sp");
  // A word caught while changing must not reach the setpoint.
  a_sp_hold: assert property (
    ss_q == 16'h0001 && $past(ss_q) == 16'h0001 &&
    $past(analog_sp_i, 3) != $past(analog_sp_i, 4) |=>
    $stable(setpoint_o)) else $error("sp hold");
  c_din: cover property (rs_q == 16'h0002 && run_o);
  c_ana: cover property (ss_q == 16'h0001 && setpoint_o != 0);
  c_err: cover property (reg_err_o);
  c_sp_hold: cover property (ss_q == 16'h0001 && $changed(analog_sp_i));
endmodule // frs_props

bind frs_top frs_props #(
  .SP_W (SP_W)
) frs_props_inst (
  .core_clk_i  (core_clk_i),
  .rst_i       (rst_i),
  .reg_wr_i    (reg_wr_i),
  .reg_rd_i    (reg_rd_i),
  .reg_idx_i   (reg_idx_i),
  .reg_wdata_i (reg_wdata_i),
  .reg_rdata_o (reg_rdata_o),
  .reg_err_o   (reg_err_o),
  .din_i       (din_i),
  .analog_sp_i (analog_sp_i),
  .run_o       (run_o),
  .setpoint_o  (setpoint_o)
);

// ===== verification/frs_master.sv
/* Bus master model for the frs_top register port.
   Assumes requests are taken at the rising clock edge. */
`timescale 1ns/1ps
// ==============================
// Register port master
module frs_master (
  input  wire logic   core_clk_i,
  output logic        wr_o,
  output logic        rd_o,
  output logic [7:0]  idx_o,
  output logic [15:0] wdata_o
);
  initial {wr_o, rd_o, idx_o, wdata_o} = '0;
  // One access held over one rising edge, then strobes cleared and index and data inverted.
  task automatic acc(input logic w, input logic [7:0] i, input logic [15:0] d);
    @(negedge core_clk_i);
    {wr_o, rd_o, idx_o, wdata_o} = {w, !w, i, d};
    @(negedge core_clk_i);
    {wr_o, rd_o, idx_o, wdata_o} = {2'b00, ~i, ~d};
  endtask
endmodule // frs_master

// ===== verification/frs_top_test.sv
/* Self-checking test of frs_top through its register port.
   Assumes the master model frs_master. */
`timescale 1ns/1ps
// ==============================
// Test top
module frs_top_test;
  logic core_clk_i, rst_i, wr, rd, din, err, run;
  logic [7:0] idx;
  logic [15:0] wd, rdat, ana, sp;
  int n_fail = 0, samples_checked = 0;
  frs_master frs_master_inst (.core_clk_i, .wr_o(wr), .rd_o(rd),
    .idx_o(idx), .wdata_o(wd));
  frs_top frs_top_inst (.core_clk_i, .rst_i, .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_idx_i(idx), .reg_wdata_i(wd), .reg_rdata_o(rdat), .reg_err_o(err),
    .din_i(din), .analog_sp_i(ana), .run_o(run), .setpoint_o(sp));
  initial begin
    core_clk_i = 0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  task automatic chk(input string n, input logic [15:0] e, s);
    samples_checked++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic put(input logic [7:0] i, input logic [15:0] d);
    frs_master_inst.acc(1'b1, i, d);
    repeat (3) @(negedge core_clk_i);
  endtask
  task automatic rc(input logic [7:0] i, input logic [15:0] e);
    frs_master_inst.acc(1'b0, i, 16'h0000);
    chk("rdata", e, rdat);
  endtask
  task automatic close_out;
    $display("checks %0d fails %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Tests run in order, each leaving state for the next.
  initial begin
    {rst_i, din, ana} = {1'b1, 1'b0, 16'h0000};
    repeat (10) @(negedge core_clk_i);
    rst_i = 0;
    rc(8'h28, 16'h0000);
    rc(8'h27, 16'h0000);
    rc(8'h30, 16'h0000);
    chk("err", 16'h0001, {15'h0000, err});
    frs_master_inst.acc(1'b1, 8'h30, 16'hFFFF);
    chk("err", 16'h0001, {15'h0000, err});
    put(8'h27, 16'h0001);
    rc(8'h27, 16'h0001);
    put(8'h27, 16'h0000);
    rc(8'h27, 16'h0000);
    $display("test regs done");
    din = 1;
    put(8'h29, 16'h000F);
    chk("run", 16'h0001, {15'h0000, run});
    put(8'h26, 16'h0800);
    chk("sp", 16'h0800, sp);
    put(8'h26, 16'h0000);
    chk("run", 16'h0001, {15'h0000, run});
    put(8'h29, 16'h0000);
    chk("run", 16'h0000, {15'h0000, run});
    put(8'h28, 16'h0001);
    chk("run", 16'h0001, {15'h0000, run});
    $display("test bus done");
    put(8'h26, 16'h0800);
    put(8'h28, 16'h0002);
    chk("run", 16'h0001, {15'h0000, run});
    din = 0;
    put(8'h26, 16'h0800);
    chk("run", 16'h0000, {15'h0000, run});
    ana = 16'h1234;
    din = 1;
    put(8'h26, 16'h0000);
    chk("run", 16'h0000, {15'h0000, run});
    put(8'h27, 16'h0001);
    chk("sp", 16'h1234, sp);
    chk("run", 16'h0001, {15'h0000, run});
    ana = 16'h0567;
    repeat (2) @(negedge core_clk_i);
    put(8'h26, 16'h0800);
    chk("sp", 16'h0567, sp);
    put(8'h28, 16'h0003);
    chk("run", 16'h0000, {15'h0000, run});
    put(8'h27, 16'h0002);
    chk("sp", 16'h0000, sp);
    $display("test modes done");
    rst_i = 1;
    repeat (2) @(negedge core_clk_i);
    rst_i = 0;
    @(negedge core_clk_i);
    chk("run", 16'h0000, {15'h0000, run});
    chk("sp", 16'h0000, sp);
    rc(8'h28, 16'h0000);
    rc(8'h27, 16'h0000);
    $display("test reset done");
    close_out;
  end
  initial begin
    #50000;
    n_fail++;
    close_out;
  end
endmodule // frs_top_test
